//--- unblock_pkg.sv
// constants, register map and types of the unblock permissive trip logic
package unblock_pkg;
  localparam int CLK_PERIOD_NS = 32'h0000000A;
  localparam int MS_NS = 32'h000F4240;
  localparam int TICK_CYCLES = MS_NS / CLK_PERIOD_NS;
  localparam int TICK_W = 17;

  localparam int NUM_PHASES = 32'h00000003;
  localparam int NUM_CHAN = 32'h00000006;

  // timer figures in milliseconds, except the alarm limit in seconds
  localparam int TIME_W = 14;
  localparam logic [13:0] SEC_DELAY_MS = 14'h0014;
  localparam logic [13:0] SILENT_HOLD_MS = 14'h0064;
  localparam logic [13:0] DROP_OFF_MS = 14'h0064;
  localparam logic [13:0] ALARM_S = 14'h000A;
  localparam logic [13:0] MS_PER_S = 14'h03E8;
  localparam logic [13:0] ALARM_MS = 14'(ALARM_S * MS_PER_S);
  localparam logic [13:0] SILENT_MAX = ALARM_MS + 14'h0001;

  // register byte offsets
  localparam logic [4:0] REG_CTRL = 5'h00;
  localparam logic [4:0] REG_PROLONG = 5'h04;
  localparam logic [4:0] REG_STATE = 5'h08;
  localparam logic [4:0] REG_INT_STATUS = 5'h0C;
  localparam logic [4:0] REG_INT_CLEAR = 5'h10;
  localparam logic [4:0] REG_INT_ENABLE = 5'h14;

  // control fields
  localparam int CTRL_W = 5;
  localparam int CTRL_ENABLE = 0;
  localparam int CTRL_THREE_TERM = 1;
  localparam int CTRL_PHASE_SEG = 2;
  localparam int CTRL_RECLOSE_OVR = 3;
  localparam int CTRL_DIR_FWD = 4;
  localparam logic [4:0] CTRL_RESET = 5'h11;
  localparam logic [15:0] PROLONG_RESET = 16'h0032;

  // interrupt events
  localparam int INT_W = 3;
  localparam int INT_CARRIER_FAIL = 0;
  localparam int INT_SILENT_REL = 1;
  localparam int INT_OVR_REL = 2;

  typedef enum logic [1:0] {CH_QUIET, CH_SILENT, CH_RECOVER} chan_state_t;
endpackage

//--- unblock_permissive_trip_logic.sv
// unblock permissive overreach scheme for one line end, with register slave
`timescale 1ns/1ps

// one receive channel: unblock/block inputs to release and alarm
module unblock_chan (
  // clock and reset
  input wire logic core_clk,
  input wire logic rst,
  input wire logic ms_tick,
  // synchronised receive inputs
  input wire logic unblock_rx,
  input wire logic block_rx,
  // results
  output logic release_r,
  output logic silent_rel_r,
  output logic alarm_r
);
  unblock_pkg::chan_state_t state_r, state_nxt;
  logic [13:0] silent_cnt_r;
  logic [13:0] drop_cnt_r;
  logic silent;
  logic silent_rel_nxt;
  logic direct_rel;

  assign silent = !unblock_rx && !block_rx;
  // silence release window: from 20 ms up to a further 100 ms
  assign silent_rel_nxt = (state_r == unblock_pkg::CH_SILENT) &&
    (silent_cnt_r >= unblock_pkg::SEC_DELAY_MS) &&
    (silent_cnt_r < unblock_pkg::SEC_DELAY_MS +
     unblock_pkg::SILENT_HOLD_MS);
  assign direct_rel = (state_r == unblock_pkg::CH_QUIET) &&
    unblock_rx && !block_rx;

  always_comb begin
    state_nxt = state_r;
    case (state_r)
      unblock_pkg::CH_QUIET: begin
        if (silent) state_nxt = unblock_pkg::CH_SILENT;
      end
      unblock_pkg::CH_SILENT: begin
        // a blip shorter than the security delay never released anything
        if (!silent && silent_cnt_r >= unblock_pkg::SEC_DELAY_MS)
          state_nxt = unblock_pkg::CH_RECOVER;
        else if (!silent)
          state_nxt = unblock_pkg::CH_QUIET;
      end
      unblock_pkg::CH_RECOVER: begin
        if (silent)
          state_nxt = unblock_pkg::CH_SILENT;
        else if (drop_cnt_r >= unblock_pkg::DROP_OFF_MS)
          state_nxt = unblock_pkg::CH_QUIET;
      end
      default: state_nxt = unblock_pkg::CH_QUIET;
    endcase
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      state_r <= unblock_pkg::CH_QUIET;
      silent_cnt_r <= '0;
      drop_cnt_r <= '0;
    end else begin
      state_r <= state_nxt;
      if (!silent)
        silent_cnt_r <= '0;
      else if (ms_tick && silent_cnt_r != unblock_pkg::SILENT_MAX)
        silent_cnt_r <= silent_cnt_r + 14'h0001;
      if (state_r != unblock_pkg::CH_RECOVER || silent)
        drop_cnt_r <= '0;
      else if (ms_tick && drop_cnt_r != unblock_pkg::DROP_OFF_MS)
        drop_cnt_r <= drop_cnt_r + 14'h0001;
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      release_r <= 1'b0;
      silent_rel_r <= 1'b0;
      alarm_r <= 1'b0;
    end else begin
      release_r <= direct_rel || silent_rel_nxt;
      silent_rel_r <= silent_rel_nxt;
      alarm_r <= silent_cnt_r > unblock_pkg::ALARM_MS;
    end
  end

  property p_direct_release;
    @(posedge core_clk) disable iff (rst)
    (state_r == unblock_pkg::CH_QUIET && unblock_rx && !block_rx)
      |=> release_r;
  endproperty
  a_direct_release: assert property (p_direct_release)
    else $error("direct unblock release missing");

  sequence s_silence_matures;
    silent && state_r == unblock_pkg::CH_SILENT &&
      silent_cnt_r == unblock_pkg::SEC_DELAY_MS;
  endsequence
  property p_silence_release;
    @(posedge core_clk) disable iff (rst)
    s_silence_matures |=> release_r && silent_rel_r;
  endproperty
  a_silence_release: assert property (p_silence_release)
    else $error("silence release not issued after security delay");

  property p_no_early_release;
    @(posedge core_clk) disable iff (rst)
    (silent && silent_cnt_r < unblock_pkg::SEC_DELAY_MS &&
     $past(silent)) |=> !silent_rel_r;
  endproperty
  a_no_early_release: assert property (p_no_early_release)
    else $error("silence release before security delay");

  property p_release_withdrawn;
    @(posedge core_clk) disable iff (rst)
    (silent && silent_cnt_r >= unblock_pkg::SEC_DELAY_MS +
     unblock_pkg::SILENT_HOLD_MS) |=> !release_r;
  endproperty
  a_release_withdrawn: assert property (p_release_withdrawn)
    else $error("silence release held past its window");

  property p_drop_off;
    @(posedge core_clk) disable iff (rst)
    (state_r == unblock_pkg::CH_RECOVER) |=> !release_r;
  endproperty
  a_drop_off: assert property (p_drop_off)
    else $error("release during drop-off interval");

  property p_alarm;
    @(posedge core_clk) disable iff (rst)
    (silent_cnt_r > unblock_pkg::ALARM_MS) |=> alarm_r;
  endproperty
  a_alarm: assert property (p_alarm)
    else $error("channel-loss alarm missing after long silence");
endmodule

module unblock_permissive_trip_logic #(
  parameter int TICK_CYCLES = unblock_pkg::TICK_CYCLES
) (
  // clock and reset
  input wire logic core_clk,
  input wire logic rst,
  // avalon-mm slave
  input wire logic [4:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  // carrier receive pins, index end*3+phase
  input wire logic [5:0] unblock_rx_input,
  input wire logic [5:0] block_rx_input,
  input wire logic reclose_zone_enable_input,
  // protection core, same clock
  input wire logic [2:0] overreach_fwd_fault,
  input wire logic fault_detect,
  input wire logic trip_issued,
  input wire logic other_zone_trip_req,
  // outputs
  output logic [2:0] tx_unblock_key,
  output logic [2:0] overreach_release,
  output logic other_zone_trip,
  output logic echo_start,
  output logic carrier_fail_alarm,
  output logic irq
);
  localparam int SYNC_W = 13;

  logic [SYNC_W-1:0] sync1_r, sync2_r;
  logic [16:0] tick_cnt_r;
  logic ms_tick_r;
  logic [4:0] ctrl_r;
  logic [15:0] prolong_r;
  logic [2:0] int_status_r, int_enable_r;
  logic [15:0] prolong_cnt_r [3];
  logic [5:0] chan_rel, chan_silent, chan_alarm;
  logic [5:0] ub_s, bl_s;
  logic reclose_en_s;

  // pins pass two flops before any logic reads them
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      sync1_r <= '0;
      sync2_r <= '0;
    end else begin
      sync1_r <= {reclose_zone_enable_input, block_rx_input,
                  unblock_rx_input};
      sync2_r <= sync1_r;
    end
  end
  assign ub_s = sync2_r[5:0];
  assign bl_s = sync2_r[11:6];
  assign reclose_en_s = sync2_r[12];

  // common millisecond tick
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      tick_cnt_r <= '0;
      ms_tick_r <= 1'b0;
    end else if (tick_cnt_r == 17'(TICK_CYCLES - 1)) begin
      tick_cnt_r <= '0;
      ms_tick_r <= 1'b1;
    end else begin
      tick_cnt_r <= tick_cnt_r + 17'h00001;
      ms_tick_r <= 1'b0;
    end
  end

  genvar gc;
  generate
    for (gc = 0; gc < unblock_pkg::NUM_CHAN; gc++) begin : g_chan
      unblock_chan u_chan (
        .core_clk(core_clk),
        .rst(rst),
        .ms_tick(ms_tick_r),
        .unblock_rx(ub_s[gc]),
        .block_rx(bl_s[gc]),
        .release_r(chan_rel[gc]),
        .silent_rel_r(chan_silent[gc]),
        .alarm_r(chan_alarm[gc])
      );
    end
  endgenerate

  wire scheme_on = ctrl_r[unblock_pkg::CTRL_ENABLE] &&
    ctrl_r[unblock_pkg::CTRL_DIR_FWD];
  wire three_term = ctrl_r[unblock_pkg::CTRL_THREE_TERM];
  wire phase_seg = ctrl_r[unblock_pkg::CTRL_PHASE_SEG];
  // without segregation phase channel 0 of each end carries all phases
  wire [2:0] phase_mask = phase_seg ? 3'h7 : 3'h1;
  wire [5:0] chan_mask = {three_term ? phase_mask : 3'h0, phase_mask};
  wire [2:0] fault_eff = phase_seg ? overreach_fwd_fault :
    {3{|overreach_fwd_fault}};
  wire [2:0] send_req = scheme_on ? fault_eff : 3'h0;
  wire [2:0] rel_a = phase_seg ? chan_rel[2:0] : {3{chan_rel[0]}};
  wire [2:0] rel_b = phase_seg ? chan_rel[5:3] : {3{chan_rel[3]}};
  wire [2:0] rx_ok = three_term ? (rel_a & rel_b) : rel_a;
  wire path_fault = |(chan_alarm & chan_mask);
  wire reclose_ovr = path_fault && reclose_en_s &&
    ctrl_r[unblock_pkg::CTRL_RECLOSE_OVR];
  wire [2:0] ovr_rel_nxt = send_req & (rx_ok | {3{reclose_ovr}});
  wire [5:0] ub_used = ub_s & chan_mask;
  wire echo_nxt = scheme_on && (|ub_used) && !fault_detect;
  logic [2:0] tx_nxt;

  // send prolongation: only armed while a trip command is present
  genvar gp;
  generate
    for (gp = 0; gp < unblock_pkg::NUM_PHASES; gp++) begin : g_phase
      assign tx_nxt[gp] = send_req[gp] || (prolong_cnt_r[gp] != 16'h0000);
      always_ff @(posedge core_clk or posedge rst) begin
        if (rst)
          prolong_cnt_r[gp] <= '0;
        else if (send_req[gp] && trip_issued)
          prolong_cnt_r[gp] <= prolong_r;
        else if (send_req[gp])
          prolong_cnt_r[gp] <= '0;
        else if (ms_tick_r && prolong_cnt_r[gp] != 16'h0000)
          prolong_cnt_r[gp] <= prolong_cnt_r[gp] - 16'h0001;
      end
    end
  endgenerate

  // interrupt events on rising edges of carrier fail and releases
  wire silent_now = |(chan_silent & chan_mask);
  logic silent_seen_r;
  wire [2:0] int_events = {
    |(ovr_rel_nxt & ~overreach_release),
    silent_now && !silent_seen_r,
    path_fault && !carrier_fail_alarm};

  // register slave, one wait state per access
  wire req = (avs_read || avs_write) && avs_waitrequest;
  wire wr_go = avs_write && !avs_waitrequest;
  wire wr_ctrl = wr_go && avs_address == unblock_pkg::REG_CTRL &&
    avs_byteenable[0];
  wire wr_prol = wr_go && avs_address == unblock_pkg::REG_PROLONG;
  wire wr_clr = wr_go && avs_address == unblock_pkg::REG_INT_CLEAR &&
    avs_byteenable[0];
  wire wr_en = wr_go && avs_address == unblock_pkg::REG_INT_ENABLE &&
    avs_byteenable[0];
  wire [2:0] clr_bits = wr_clr ? avs_writedata[2:0] : 3'h0;
  // a new event wins over a clear landing in the same cycle
  wire [2:0] int_status_nxt = (int_status_r & ~clr_bits) | int_events;
  wire [31:0] state_word = {19'h00000, carrier_fail_alarm, chan_silent,
    overreach_release, tx_unblock_key};
  wire [31:0] rd_mux =
    avs_address == unblock_pkg::REG_CTRL ? {27'h0000000, ctrl_r} :
    avs_address == unblock_pkg::REG_PROLONG ? {16'h0000, prolong_r} :
    avs_address == unblock_pkg::REG_STATE ? state_word :
    avs_address == unblock_pkg::REG_INT_STATUS ?
      {29'h00000000, int_status_r} :
    avs_address == unblock_pkg::REG_INT_ENABLE ?
      {29'h00000000, int_enable_r} : 32'h00000000;

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      avs_waitrequest <= 1'b1;
      avs_readdata <= '0;
    end else begin
      avs_waitrequest <= !req;
      if (req && avs_read)
        avs_readdata <= rd_mux;
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      ctrl_r <= unblock_pkg::CTRL_RESET;
      prolong_r <= unblock_pkg::PROLONG_RESET;
      int_enable_r <= '0;
    end else begin
      if (wr_ctrl)
        ctrl_r <= avs_writedata[4:0];
      if (wr_prol && avs_byteenable[0])
        prolong_r[7:0] <= avs_writedata[7:0];
      if (wr_prol && avs_byteenable[1])
        prolong_r[15:8] <= avs_writedata[15:8];
      if (wr_en)
        int_enable_r <= avs_writedata[2:0];
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      int_status_r <= '0;
      irq <= 1'b0;
      silent_seen_r <= 1'b0;
    end else begin
      int_status_r <= int_status_nxt;
      irq <= |(int_status_nxt & int_enable_r);
      silent_seen_r <= silent_now;
    end
  end

  // scheme outputs
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      tx_unblock_key <= '0;
      overreach_release <= '0;
      other_zone_trip <= 1'b0;
      echo_start <= 1'b0;
      carrier_fail_alarm <= 1'b0;
    end else begin
      tx_unblock_key <= tx_nxt;
      overreach_release <= ovr_rel_nxt;
      other_zone_trip <= other_zone_trip_req;
      echo_start <= echo_nxt;
      carrier_fail_alarm <= path_fault;
    end
  end

  property p_tx_key;
    @(posedge core_clk) disable iff (rst)
    (scheme_on && overreach_fwd_fault[0]) |=> tx_unblock_key[0];
  endproperty
  a_tx_key: assert property (p_tx_key)
    else $error("unblock tone not keyed on forward overreach fault");

  property p_monitor_tone;
    @(posedge core_clk) disable iff (rst)
    (!send_req[0] && prolong_cnt_r[0] == 16'h0000) |=> !tx_unblock_key[0];
  endproperty
  a_monitor_tone: assert property (p_monitor_tone)
    else $error("unblock tone keyed without cause");

  property p_prolong_needs_trip;
    @(posedge core_clk) disable iff (rst)
    (send_req[0] && !trip_issued) |=> prolong_cnt_r[0] == 16'h0000;
  endproperty
  a_prolong_needs_trip: assert property (p_prolong_needs_trip)
    else $error("send prolongation armed without a trip");

  property p_other_zone;
    @(posedge core_clk) disable iff (rst)
    other_zone_trip_req |=> other_zone_trip;
  endproperty
  a_other_zone: assert property (p_other_zone)
    else $error("other zone trip delayed or lost");

  property p_dir_fwd;
    @(posedge core_clk) disable iff (rst)
    !ctrl_r[unblock_pkg::CTRL_DIR_FWD] |=> (overreach_release == 3'h0);
  endproperty
  a_dir_fwd: assert property (p_dir_fwd)
    else $error("release with overreach direction not forward");

  property p_three_and;
    @(posedge core_clk) disable iff (rst)
    (three_term && !rel_b[0] && !reclose_ovr) |=> !overreach_release[0];
  endproperty
  a_three_and: assert property (p_three_and)
    else $error("three-terminal release without both ends");

  property p_reclose;
    @(posedge core_clk) disable iff (rst)
    (reclose_ovr && send_req[1]) |=> overreach_release[1];
  endproperty
  a_reclose: assert property (p_reclose)
    else $error("reclose did not activate overreach zone");

  property p_echo;
    @(posedge core_clk) disable iff (rst)
    fault_detect |=> !echo_start;
  endproperty
  a_echo: assert property (p_echo)
    else $error("echo started despite local fault detection");
endmodule

//--- carrier_link_model.sv
// carrier equipment model for both directions of the protection link
`timescale 1ns/1ps
module carrier_link_model (
  // far relay keying and channel condition
  input wire logic [5:0] remote_key,
  input wire logic [5:0] chan_dead,
  // local transmit side
  input wire logic [2:0] tx_key,
  output logic [2:0] tone_unblock,
  // receive pins of the local relay
  output logic [5:0] unblock_rx,
  output logic [5:0] block_rx
);
  // keyed tone replaces the monitoring tone one for one
  assign tone_unblock = tx_key;
  // attenuated channel delivers neither tone, never a stale level
  assign unblock_rx = remote_key & ~chan_dead;
  assign block_rx = ~remote_key & ~chan_dead;
endmodule

//--- unblock_permissive_trip_logic_tb_top.sv
// self-checking bench for the unblock permissive trip logic
`timescale 1ns/1ps
module unblock_permissive_trip_logic_tb_top;
  localparam int TICK = 2;
  logic core_clk, rst;
  logic [4:0] avs_address;
  logic avs_read, avs_write, avs_waitrequest;
  logic [31:0] avs_writedata, avs_readdata, rd;
  logic [3:0] avs_byteenable;
  logic [5:0] unblock_rx_input, block_rx_input, remote_key, chan_dead;
  logic reclose_zone_enable_input, fault_detect, trip_issued;
  logic other_zone_trip_req, other_zone_trip, echo_start;
  logic carrier_fail_alarm, irq;
  logic [2:0] fault, tx_unblock_key, overreach_release, tone_unblock;
  int miscompares, cmp_count;

  unblock_permissive_trip_logic #(.TICK_CYCLES(TICK)) uut (
    .core_clk(core_clk), .rst(rst),
    .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest),
    .unblock_rx_input(unblock_rx_input), .block_rx_input(block_rx_input),
    .reclose_zone_enable_input(reclose_zone_enable_input),
    .overreach_fwd_fault(fault), .fault_detect(fault_detect),
    .trip_issued(trip_issued), .other_zone_trip_req(other_zone_trip_req),
    .tx_unblock_key(tx_unblock_key),
    .overreach_release(overreach_release),
    .other_zone_trip(other_zone_trip), .echo_start(echo_start),
    .carrier_fail_alarm(carrier_fail_alarm), .irq(irq)
  );

  carrier_link_model link (
    .remote_key(remote_key), .chan_dead(chan_dead),
    .tx_key(tx_unblock_key), .tone_unblock(tone_unblock),
    .unblock_rx(unblock_rx_input), .block_rx(block_rx_input)
  );

  initial begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end

  task automatic results();
    $display("comparisons %0d mismatches %0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  task automatic chk(input string what, input logic [31:0] seen, exp);
    cmp_count++;
    if (seen !== exp) begin
      miscompares++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // one access; request held until waitrequest is sampled low
  task automatic bus(input logic wr, input logic [4:0] a,
                     input logic [31:0] d);
    int n;
    n = 0;
    @(posedge core_clk);
    avs_address <= a;
    avs_write <= wr;
    avs_read <= ~wr;
    avs_writedata <= d;
    do begin
      @(posedge core_clk);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 20);
    if (avs_waitrequest !== 1'b0) begin
      miscompares++;
      results();
    end
    rd = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
  endtask

  task automatic ms(input int m);
    repeat (m * TICK) @(posedge core_clk);
  endtask

  initial begin
    repeat (40000) @(posedge core_clk);
    miscompares++;
    results();
  end

  initial begin
    rst = 1'b1;
    avs_address = 5'h00;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_writedata = 32'h00000000;
    avs_byteenable = 4'hF;
    remote_key = 6'h00;
    chan_dead = 6'h00;
    reclose_zone_enable_input = 1'b0;
    fault = 3'h0;
    fault_detect = 1'b1;
    trip_issued = 1'b0;
    other_zone_trip_req = 1'b0;
    repeat (3) @(posedge core_clk);
    rst <= 1'b0;
    bus(1'b0, unblock_pkg::REG_CTRL, 32'h0);
    chk("ctrl reset", rd, 32'h00000011);
    bus(1'b0, unblock_pkg::REG_PROLONG, 32'h0);
    chk("prolong reset", rd, 32'h00000032);
    bus(1'b1, 5'h18, 32'hFFFFFFFF);
    bus(1'b0, 5'h18, 32'h0);
    chk("unmapped", rd, 32'h00000000);
    ms(3);
    chk("tx quiet", tx_unblock_key, 3'h0);
    fault <= 3'h1;
    ms(1);
    chk("tx fault", |tx_unblock_key, 1'b1);
    fault <= 3'h0;
    ms(1);
    chk("tx no trip", tx_unblock_key, 3'h0);
    fault <= 3'h1;
    trip_issued <= 1'b1;
    ms(1);
    fault <= 3'h0;
    trip_issued <= 1'b0;
    ms(40);
    chk("tx prolonged", |tx_unblock_key, 1'b1);
    ms(20);
    chk("tx prolong end", tx_unblock_key, 3'h0);
    other_zone_trip_req <= 1'b1;
    repeat (2) @(posedge core_clk);
    chk("other zone", other_zone_trip, 1'b1);
    other_zone_trip_req <= 1'b0;
    fault <= 3'h1;
    remote_key <= 6'h01;
    ms(3);
    chk("direct release", |overreach_release, 1'b1);
    fault <= 3'h0;
    ms(1);
    chk("no local fault", overreach_release, 3'h0);
    fault_detect <= 1'b0;
    ms(3);
    chk("echo", echo_start, 1'b1);
    fault_detect <= 1'b1;
    remote_key <= 6'h00;
    fault <= 3'h1;
    ms(3);
    chk("block tone", overreach_release, 3'h0);
    chk("echo off", echo_start, 1'b0);
    chan_dead <= 6'h3F;
    ms(15);
    chk("silence early", overreach_release, 3'h0);
    ms(10);
    chk("silence rel", |overreach_release, 1'b1);
    ms(90);
    chk("silence hold", |overreach_release, 1'b1);
    ms(15);
    chk("silence end", overreach_release, 3'h0);
    chan_dead <= 6'h00;
    remote_key <= 6'h01;
    ms(90);
    chk("drop-off", overreach_release, 3'h0);
    ms(20);
    chk("quiet again", |overreach_release, 1'b1);
    fault <= 3'h0;
    remote_key <= 6'h00;
    bus(1'b1, unblock_pkg::REG_INT_CLEAR, 32'h7);
    chan_dead <= 6'h3F;
    ms(9900);
    chk("alarm early", carrier_fail_alarm, 1'b0);
    ms(200);
    chk("alarm", carrier_fail_alarm, 1'b1);
    bus(1'b0, unblock_pkg::REG_INT_STATUS, 32'h0);
    chk("int status", rd, 32'h00000003);
    bus(1'b1, unblock_pkg::REG_INT_ENABLE, 32'h1);
    ms(1);
    chk("irq on", irq, 1'b1);
    bus(1'b1, unblock_pkg::REG_INT_ENABLE, 32'h0);
    ms(1);
    chk("irq masked", irq, 1'b0);
    bus(1'b1, unblock_pkg::REG_INT_CLEAR, 32'h7);
    bus(1'b0, unblock_pkg::REG_INT_STATUS, 32'h0);
    chk("int cleared", rd, 32'h00000000);
    bus(1'b1, unblock_pkg::REG_INT_ENABLE, 32'h7);
    fault <= 3'h1;
    ms(3);
    chk("path fail no ar", overreach_release, 3'h0);
    reclose_zone_enable_input <= 1'b1;
    bus(1'b1, unblock_pkg::REG_CTRL, 32'h19);
    ms(3);
    chk("ar release", |overreach_release, 1'b1);
    chk("irq release", irq, 1'b1);
    bus(1'b0, unblock_pkg::REG_STATE, 32'h0);
    chk("state word", rd, 32'h0000103F);
    bus(1'b0, unblock_pkg::REG_INT_CLEAR, 32'h0);
    chk("clear reads zero", rd, 32'h00000000);
    reclose_zone_enable_input <= 1'b0;
    chan_dead <= 6'h00;
    bus(1'b1, unblock_pkg::REG_CTRL, 32'h13);
    remote_key <= 6'h01;
    ms(120);
    chk("one end only", overreach_release, 3'h0);
    remote_key <= 6'h09;
    ms(3);
    chk("both ends", |overreach_release, 1'b1);
    fault_detect <= 1'b0;
    remote_key <= 6'h08;
    ms(3);
    chk("echo one end", echo_start, 1'b1);
    fault_detect <= 1'b1;
    remote_key <= 6'h00;
    bus(1'b1, unblock_pkg::REG_CTRL, 32'h15);
    fault <= 3'h2;
    ms(3);
    chk("tx phase", tx_unblock_key, 3'h2);
    chk("tone phase", tone_unblock, 3'h2);
    fault <= 3'h7;
    remote_key <= 6'h02;
    ms(3);
    chk("rel phase", overreach_release, 3'h2);
    bus(1'b1, unblock_pkg::REG_CTRL, 32'h01);
    ms(3);
    chk("tx reverse", tx_unblock_key, 3'h0);
    chk("rel reverse", overreach_release, 3'h0);
    bus(1'b1, unblock_pkg::REG_CTRL, 32'h10);
    ms(3);
    chk("tx disabled", tx_unblock_key, 3'h0);
    avs_byteenable <= 4'h1;
    bus(1'b1, unblock_pkg::REG_PROLONG, 32'h00001234);
    avs_byteenable <= 4'hF;
    bus(1'b0, unblock_pkg::REG_PROLONG, 32'h0);
    chk("prolong low lane", rd, 32'h00000034);
    results();
  end
endmodule
